// [design/cmrb_params.svh]
// cmrb_params.svh - offsets, field positions, reset values and timing for the register bank
`ifndef CMRB_PARAMS_SVH
`define CMRB_PARAMS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define CMRB_OFS_CFGA 12'h000
`define CMRB_OFS_THR 12'h004
`define CMRB_OFS_DTM 12'h008
`define CMRB_OFS_DCC 12'h00C
`define CMRB_OFS_RES 12'h100
`define CMRB_RES_COUNT 88

// ----------------------------------------
// result array indices
// ----------------------------------------
`define CMRB_IDX_CELL 0
`define CMRB_IDX_AVG 16
`define CMRB_IDX_FILT 32
`define CMRB_IDX_SPIN 48
`define CMRB_IDX_AUX 64
`define CMRB_IDX_RAUX 74
`define CMRB_IDX_VPV 84
`define CMRB_IDX_VMV 85
`define CMRB_IDX_SECOND_REFERENCE_RESULT 86
`define CMRB_IDX_DIE_TEMPERATURE_RESULT 87

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define CMRB_THR_HIGH_LSB 12
`define CMRB_DTM_RANGE_BIT 6
`define CMRB_DTM_EN_BIT 7
`define CMRB_RST_LOW_THR 12'h800
`define CMRB_RST_HIGH_THR 12'h7FF
`define CMRB_RES_NEG_FS 16'h8000
`define CMRB_RES_POS_FS 16'h7FFF
`define CMRB_COARSE_STEP_MIN 5'h10

// ----------------------------------------
// timing
// ----------------------------------------
`define CMRB_CLK_HZ 40000000
`define CMRB_MINUTE_S 60

`endif

// [design/cmrb_pkg.sv]
// cmrb_pkg.sv - types shared by the cell monitor register bank
package cmrb_pkg;

    // one conversion result delivered by the measurement engine
    typedef struct packed {
        logic valid;
        logic [6:0] index;
        logic [15:0] data;
    } cmrb_result_t;

    // one-cycle command and event pulses
    typedef struct packed {
        logic clear_cell_results_cmd;
        logic clear_filtered_results_cmd;
        logic clear_spin_results_cmd;
        logic clear_auxiliary_results_cmd;
        logic sleep_entry;
        logic spin_convert_cmd;
        logic cell_convert_cmd;
        logic mute_on;
        logic mute_off;
        logic freeze_on;
        logic freeze_off;
        logic extended_balance_entry;
    } cmrb_cmd_t;

    // discharge timer monitor states
    typedef enum logic [1:0] {
        DTM_IDLE,
        DTM_RUN,
        DTM_EXPIRED
    } cmrb_dtm_state_t;

endpackage

// [design/cmrb_top.sv]
// cmrb_top.sv - cell monitor register bank with APB slave
`timescale 1ns/1ps
`default_nettype none
`include "cmrb_params.svh"

// What this block does
// - mute status set forces every shunt switch off
// - freeze status set blocks every conversion update; clear commands still reset results
// - low threshold is field times 16 steps of 150 uV; resets 0x800
// - high threshold scaled the same way; resets 0x7FF
// - timer monitor starts on extended balancing entry only when enabled
// - range bit picks 1-minute or 16-minute increments
// - timeout write loads a count; read returns remaining count
// - timeout reads 1 at last increment, 0 when expired or unset
// - each shunt bit holds its cell switch on or off; default off
// - sixteen cell results reset to 0x8000 on power-up and cell clear
// - averaged result is mean of 8 conversions; cleared by cell clear
// - filtered results reset on power-up and their own clear only
// - spin results updated after spin or cell convert; own clear
// - ten aux results plus ten redundant ones in common format
// - stack result resets 0x8000 on power-up, sleep, aux clear
// - bottom input result resets 0x8000 on power-up, sleep, aux clear
// - second reference result resets 0x8000 on power-up, sleep, aux clear
// - die temperature resets 0x7FFF on power-up and sleep, 0x8000 on aux clear
// - results are signed codes, 150 uV step, zero at 1.5 V
// - threshold fields are 12 bits, 2.4 mV step, zero at 1.5 V
module cmrb_top #(
    parameter logic [31:0] MINUTE_CYCLES = 32'(64'(`CMRB_MINUTE_S) * 64'(`CMRB_CLK_HZ))
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // measurement engine side
    input wire cmrb_pkg::cmrb_result_t result_in,
    input wire cmrb_pkg::cmrb_cmd_t cmd_in,
    // cell side
    output logic [15:0] cell_shunt_switch,
    output logic [15:0] cell_under_flags,
    output logic [15:0] cell_over_flags
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic discharge_silence_flag;
    logic result_freeze_flag;
    logic [11:0] cell_low_threshold;
    logic [11:0] cell_high_threshold;
    logic discharge_timer_monitor_enable;
    logic discharge_timer_range;
    logic [5:0] discharge_timeout_count;
    logic [15:0] shunt_bits;
    logic [15:0] results [`CMRB_RES_COUNT];
    logic signed [18:0] avg_acc [16];
    logic [2:0] avg_cnt [16];
    logic spin_armed;
    cmrb_pkg::cmrb_dtm_state_t dtm_state;
    logic [31:0] tick_cnt;
    logic [4:0] inc_min;
    logic [31:0] next_prdata;
    logic next_err;
    logic wr_take;
    logic res_take;
    logic clr_sleep_aux;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // threshold field to 16-bit result code: 16 result steps per field step
    function automatic logic signed [15:0] thr_code(input logic [11:0] t);
        thr_code = {t, 4'h0};
    endfunction

    // true when the address falls in the result window
    function automatic logic is_result(input logic [11:0] a);
        is_result = (a >= `CMRB_OFS_RES) && (a < `CMRB_OFS_RES + 12'(4 * `CMRB_RES_COUNT))
            && (a[1:0] == 2'b00);
    endfunction

    // result array index from a result address
    function automatic logic [6:0] res_index(input logic [11:0] a);
        logic [11:0] d;
        d = a - `CMRB_OFS_RES;
        res_index = d[8:2];
    endfunction

    // write takes effect only at the edge where the master sees pready
    assign wr_take = psel & penable & pready & pwrite;
    // conversions land only while results are not frozen
    assign res_take = result_in.valid & ~result_freeze_flag;
    assign clr_sleep_aux = cmd_in.sleep_entry | cmd_in.clear_auxiliary_results_cmd;

    // ----------------------------------------
    // apb read mux and decode
    // ----------------------------------------
    always_comb begin
        next_prdata = 32'h0000_0000;
        next_err = 1'b0;
        if (is_result(paddr)) begin
            next_prdata = {16'h0000, results[res_index(paddr)]};
            next_err = pwrite;
        end else begin
            case (paddr)
                `CMRB_OFS_CFGA: begin
                    next_prdata = {30'h0, result_freeze_flag, discharge_silence_flag};
                    next_err = pwrite;
                end
                `CMRB_OFS_THR: begin
                    next_prdata = {8'h00, cell_high_threshold, cell_low_threshold};
                end
                `CMRB_OFS_DTM: begin
                    // remaining count, not the written value
                    next_prdata = {24'h0, discharge_timer_monitor_enable,
                        discharge_timer_range, discharge_timeout_count};
                end
                `CMRB_OFS_DCC: begin
                    next_prdata = {16'h0000, shunt_bits};
                end
                default: begin
                    next_err = 1'b1;
                end
            endcase
        end
    end

    // one wait state: answer is registered, so all outputs come from flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & penable & ~pready;
            if (psel & penable & ~pready) begin
                prdata <= pwrite ? 32'h0000_0000 : next_prdata;
                pslverr <= next_err;
            end else begin
                prdata <= 32'h0000_0000;
                pslverr <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // status flags
    // ----------------------------------------
    // set commands win over clears arriving in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            discharge_silence_flag <= 1'b0;
            result_freeze_flag <= 1'b0;
        end else begin
            if (cmd_in.mute_on) begin
                discharge_silence_flag <= 1'b1;
            end else if (cmd_in.mute_off) begin
                discharge_silence_flag <= 1'b0;
            end
            if (cmd_in.freeze_on) begin
                result_freeze_flag <= 1'b1;
            end else if (cmd_in.freeze_off) begin
                result_freeze_flag <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // writable configuration
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cell_low_threshold <= `CMRB_RST_LOW_THR;
            cell_high_threshold <= `CMRB_RST_HIGH_THR;
            discharge_timer_monitor_enable <= 1'b0;
            discharge_timer_range <= 1'b0;
            shunt_bits <= 16'h0000;
        end else if (wr_take) begin
            if (paddr == `CMRB_OFS_THR) begin
                cell_low_threshold <= pwdata[11:0];
                cell_high_threshold <= pwdata[`CMRB_THR_HIGH_LSB +: 12];
            end
            if (paddr == `CMRB_OFS_DTM) begin
                discharge_timer_monitor_enable <= pwdata[`CMRB_DTM_EN_BIT];
                discharge_timer_range <= pwdata[`CMRB_DTM_RANGE_BIT];
            end
            if (paddr == `CMRB_OFS_DCC) begin
                shunt_bits <= pwdata[15:0];
            end
        end
    end

    // ----------------------------------------
    // discharge timer monitor
    // ----------------------------------------
    // the cycle counter makes one-minute ticks; inc_min counts minutes per increment
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dtm_state <= cmrb_pkg::DTM_IDLE;
            discharge_timeout_count <= 6'h00;
            tick_cnt <= 32'h0000_0000;
            inc_min <= 5'h00;
        end else if (wr_take && paddr == `CMRB_OFS_DTM) begin
            discharge_timeout_count <= pwdata[5:0];
            tick_cnt <= 32'h0000_0000;
            inc_min <= 5'h00;
            if (!pwdata[`CMRB_DTM_EN_BIT] || pwdata[5:0] == 6'h00) begin
                dtm_state <= cmrb_pkg::DTM_IDLE;
            end else if (dtm_state == cmrb_pkg::DTM_EXPIRED) begin
                dtm_state <= cmrb_pkg::DTM_RUN;
            end
        end else begin
            case (dtm_state)
                cmrb_pkg::DTM_IDLE: begin
                    tick_cnt <= 32'h0000_0000;
                    inc_min <= 5'h00;
                    if (cmd_in.extended_balance_entry && discharge_timer_monitor_enable
                        && discharge_timeout_count != 6'h00) begin
                        dtm_state <= cmrb_pkg::DTM_RUN;
                    end
                end
                cmrb_pkg::DTM_RUN: begin
                    if (tick_cnt >= MINUTE_CYCLES - 32'h1) begin
                        tick_cnt <= 32'h0000_0000;
                        if (inc_min >= (discharge_timer_range ? `CMRB_COARSE_STEP_MIN - 5'h1
                            : 5'h00)) begin
                            inc_min <= 5'h00;
                            discharge_timeout_count <= discharge_timeout_count - 6'h01;
                            if (discharge_timeout_count == 6'h01) begin
                                dtm_state <= cmrb_pkg::DTM_EXPIRED;
                            end
                        end else begin
                            inc_min <= inc_min + 5'h01;
                        end
                    end else begin
                        tick_cnt <= tick_cnt + 32'h1;
                    end
                end
                cmrb_pkg::DTM_EXPIRED: begin
                    tick_cnt <= 32'h0000_0000;
                end
                default: begin
                    dtm_state <= cmrb_pkg::DTM_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // shunt switch drive
    // ----------------------------------------
    // mute and timer expiry override the software bits without altering them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cell_shunt_switch <= 16'h0000;
        end else if (discharge_silence_flag || dtm_state == cmrb_pkg::DTM_EXPIRED) begin
            cell_shunt_switch <= 16'h0000;
        end else begin
            cell_shunt_switch <= shunt_bits;
        end
    end

    // ----------------------------------------
    // spin update permission
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            spin_armed <= 1'b0;
        end else if (cmd_in.spin_convert_cmd || cmd_in.cell_convert_cmd) begin
            spin_armed <= 1'b1;
        end
    end

    // ----------------------------------------
    // eight-sample averaging
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 16; i++) begin
                avg_acc[i] <= 19'sh0;
                avg_cnt[i] <= 3'h0;
            end
        end else if (cmd_in.clear_cell_results_cmd) begin
            for (int i = 0; i < 16; i++) begin
                avg_acc[i] <= 19'sh0;
                avg_cnt[i] <= 3'h0;
            end
        end else if (res_take && result_in.index < 7'(`CMRB_IDX_AVG)) begin
            if (avg_cnt[result_in.index[3:0]] == 3'h7) begin
                avg_acc[result_in.index[3:0]] <= 19'sh0;
            end else begin
                avg_acc[result_in.index[3:0]] <= avg_acc[result_in.index[3:0]]
                    + 19'(signed'(result_in.data));
            end
            avg_cnt[result_in.index[3:0]] <= avg_cnt[result_in.index[3:0]] + 3'h1;
        end
    end

    // ----------------------------------------
    // result array
    // ----------------------------------------
    // conversions land first, then clears override so a clear is never lost
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < `CMRB_RES_COUNT; i++) begin
                results[i] <= `CMRB_RES_NEG_FS;
            end
            results[`CMRB_IDX_DIE_TEMPERATURE_RESULT] <= `CMRB_RES_POS_FS;
        end else begin
            if (res_take) begin
                if (result_in.index < 7'(`CMRB_IDX_AVG)) begin
                    results[result_in.index] <= result_in.data;
                    if (avg_cnt[result_in.index[3:0]] == 3'h7) begin
                        results[result_in.index + 7'(`CMRB_IDX_AVG)] <=
                            16'((avg_acc[result_in.index[3:0]]
                            + 19'(signed'(result_in.data))) >>> 3);
                    end
                end else if (result_in.index >= 7'(`CMRB_IDX_SPIN)
                    && result_in.index < 7'(`CMRB_IDX_AUX)) begin
                    if (spin_armed) begin
                        results[result_in.index] <= result_in.data;
                    end
                end else if (result_in.index >= 7'(`CMRB_IDX_FILT)
                    && result_in.index < 7'(`CMRB_RES_COUNT)) begin
                    results[result_in.index] <= result_in.data;
                end
            end
            if (cmd_in.clear_cell_results_cmd) begin
                for (int i = `CMRB_IDX_CELL; i < `CMRB_IDX_FILT; i++) begin
                    results[i] <= `CMRB_RES_NEG_FS;
                end
            end
            if (cmd_in.clear_filtered_results_cmd) begin
                for (int i = `CMRB_IDX_FILT; i < `CMRB_IDX_SPIN; i++) begin
                    results[i] <= `CMRB_RES_NEG_FS;
                end
            end
            if (cmd_in.clear_spin_results_cmd) begin
                for (int i = `CMRB_IDX_SPIN; i < `CMRB_IDX_AUX; i++) begin
                    results[i] <= `CMRB_RES_NEG_FS;
                end
            end
            if (clr_sleep_aux) begin
                results[`CMRB_IDX_VPV] <= `CMRB_RES_NEG_FS;
                results[`CMRB_IDX_VMV] <= `CMRB_RES_NEG_FS;
                results[`CMRB_IDX_SECOND_REFERENCE_RESULT] <= `CMRB_RES_NEG_FS;
                results[`CMRB_IDX_DIE_TEMPERATURE_RESULT] <= cmd_in.sleep_entry ? `CMRB_RES_POS_FS
                    : `CMRB_RES_NEG_FS;
            end
        end
    end

    // ----------------------------------------
    // threshold comparison
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cell_under_flags <= 16'h0000;
            cell_over_flags <= 16'h0000;
        end else if (res_take && result_in.index < 7'(`CMRB_IDX_AVG)) begin
            cell_under_flags[result_in.index[3:0]] <=
                signed'(result_in.data) < thr_code(cell_low_threshold);
            cell_over_flags[result_in.index[3:0]] <=
                signed'(result_in.data) > thr_code(cell_high_threshold);
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    sequence s_access_wait;
        psel && penable && !pready;
    endsequence

    property p_bus_answer;
        @(posedge pclk) disable iff (!presetn) s_access_wait |=> pready ##1 !pready;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("apb answer not one wait");

    property p_mute_off;
        @(posedge pclk) disable iff (!presetn)
            discharge_silence_flag |=> cell_shunt_switch == 16'h0000;
    endproperty
    a_mute_off: assert property (p_mute_off) else $error("shunt on while muted");

    property p_freeze;
        @(posedge pclk) disable iff (!presetn)
            result_freeze_flag && !cmd_in.clear_cell_results_cmd |=> $stable(results[0]);
    endproperty
    a_freeze: assert property (p_freeze) else $error("result moved while frozen");

    property p_cell_clear;
        @(posedge pclk) disable iff (!presetn)
            cmd_in.clear_cell_results_cmd |=> results[0] == 16'h8000 && results[16] == 16'h8000;
    endproperty
    a_cell_clear: assert property (p_cell_clear) else $error("cell clear missed");

    property p_filt_clear;
        @(posedge pclk) disable iff (!presetn)
            cmd_in.clear_filtered_results_cmd |=> results[47] == 16'h8000;
    endproperty
    a_filt_clear: assert property (p_filt_clear) else $error("filtered clear missed");

    property p_temp_sleep;
        @(posedge pclk) disable iff (!presetn)
            cmd_in.sleep_entry |=> results[87] == 16'h7FFF && results[84] == 16'h8000;
    endproperty
    a_temp_sleep: assert property (p_temp_sleep) else $error("sleep reset wrong");

    property p_temp_aux;
        @(posedge pclk) disable iff (!presetn)
            cmd_in.clear_auxiliary_results_cmd && !cmd_in.sleep_entry
            |=> results[87] == 16'h8000 && results[86] == 16'h8000;
    endproperty
    a_temp_aux: assert property (p_temp_aux) else $error("aux clear wrong");

    property p_expired_off;
        @(posedge pclk) disable iff (!presetn)
            dtm_state == cmrb_pkg::DTM_EXPIRED |-> discharge_timeout_count == 6'h00
            ##1 cell_shunt_switch == 16'h0000;
    endproperty
    a_expired_off: assert property (p_expired_off) else $error("shunt on after expiry");

    property p_shunt_follow;
        @(posedge pclk) disable iff (!presetn)
            !discharge_silence_flag && dtm_state != cmrb_pkg::DTM_EXPIRED
            |=> cell_shunt_switch == $past(shunt_bits);
    endproperty
    a_shunt_follow: assert property (p_shunt_follow) else $error("shunt not from bits");

endmodule
`default_nettype wire

// [verif/cmrb_top_tb_top.sv]
// cmrb_top_tb_top.sv - self-checking bench for the cell monitor register bank
`timescale 1ns/1ps
`default_nettype none
`include "cmrb_params.svh"
module cmrb_top_tb_top;
    // ----------------------------------------
    // signals and design
    // ----------------------------------------
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err;
    cmrb_pkg::cmrb_result_t res = '0;
    cmrb_pkg::cmrb_cmd_t cmd = '0;
    logic [15:0] shunt, under, over, m, x;
    int fail_count = 0, n_compared = 0;
    // clock period 25 ns
    initial forever #12.5 pclk = ~pclk;
    // a short minute keeps the timer scenarios within a few hundred cycles
    cmrb_top #(.MINUTE_CYCLES(32'h4)) i_cmrb_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .result_in(res), .cmd_in(cmd),
        .cell_shunt_switch(shunt), .cell_under_flags(under), .cell_over_flags(over));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("compared %0d mismatched %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // request held until the rising edge that samples pready high, then one idle edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (pready !== 1'b1) begin
            fail_count++;
            give_verdict();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic ee);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
        chk({31'h0, err}, {31'h0, ee});
    endtask
    task automatic pulse(input logic [11:0] c);
        cmd <= c;
        @(posedge pclk);
        cmd <= '0;
        // flag then output flop: two edges before the effect can be read
        repeat (2) @(posedge pclk);
    endtask
    task automatic wres(input int i, input logic [15:0] d);
        res <= {1'b1, 7'(i), d};
        @(posedge pclk);
        res <= '0;
        @(posedge pclk);
    endtask
    function automatic logic [11:0] ra(input int i);
        return `CMRB_OFS_RES + 12'(4 * i);
    endfunction
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        int c, sum;
        logic [11:0] lw;
        void'($urandom(32'hE884B687));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdc(`CMRB_OFS_CFGA, 32'h0, 1'b0);
        rdc(`CMRB_OFS_THR, 32'h007FF800, 1'b0);
        rdc(`CMRB_OFS_DTM, 32'h0, 1'b0);
        rdc(`CMRB_OFS_DCC, 32'h0, 1'b0);
        for (int i = 0; i < 88; i++) rdc(ra(i), (i == 87) ? 32'h7FFF : 32'h8000, 1'b0);
        rdc(12'h0F0, 32'h0, 1'b1);
        $display("test reset values done");
        // threshold compare on one random cell, both sides of the low boundary, just above the high one
        c = $urandom % 16;
        lw = 12'h100 + 12'($urandom % 256);
        apb(1'b1, `CMRB_OFS_THR, {8'h0, 12'h400, lw});
        rdc(`CMRB_OFS_THR, {8'h0, 12'h400, lw}, 1'b0);
        wres(c, {lw, 4'h0} - 16'h1);
        chk({31'h0, under[c]}, 32'h1);
        wres(c, {lw, 4'h0});
        chk({31'h0, under[c]}, 32'h0);
        wres(c, 16'h4001);
        chk({31'h0, over[c]}, 32'h1);
        rdc(ra(c), 32'h4001, 1'b0);
        // freeze blocks updates, read-only places refuse writes
        pulse(12'h004);
        rdc(`CMRB_OFS_CFGA, 32'h2, 1'b0);
        wres(c, 16'h1234);
        rdc(ra(c), 32'h4001, 1'b0);
        pulse(12'h002);
        apb(1'b1, ra(c), 32'h1);
        chk({31'h0, err}, 32'h1);
        rdc(ra(c), 32'h4001, 1'b0);
        apb(1'b1, `CMRB_OFS_CFGA, 32'h3);
        chk({31'h0, err}, 32'h1);
        rdc(`CMRB_OFS_CFGA, 32'h0, 1'b0);
        $display("test thresholds and freeze done");
        // average of eight on a fresh cell, then the separate clears
        c = (c + 1) % 16;
        sum = 0;
        for (int i = 0; i < 8; i++) begin
            x = 16'($urandom);
            sum += int'($signed(x));
            wres(c, x);
        end
        rdc(ra(16 + c), {16'h0, 16'(sum >>> 3)}, 1'b0);
        wres(32 + c, 16'h0ABC);
        pulse(12'h800);
        rdc(ra(c), 32'h8000, 1'b0);
        rdc(ra(16 + c), 32'h8000, 1'b0);
        rdc(ra(32 + c), 32'h0ABC, 1'b0);
        pulse(12'h400);
        rdc(ra(32 + c), 32'h8000, 1'b0);
        wres(48, 16'h0123);
        rdc(ra(48), 32'h8000, 1'b0);
        pulse(12'h040);
        wres(48, 16'h0123);
        rdc(ra(48), 32'h0123, 1'b0);
        pulse(12'h200);
        rdc(ra(48), 32'h8000, 1'b0);
        $display("test averages and clears done");
        // auxiliary results, then sleep and the auxiliary clear
        for (int i = 64; i < 88; i++) wres(i, 16'(i));
        for (int i = 64; i < 88; i++) rdc(ra(i), 32'(i), 1'b0);
        pulse(12'h080);
        for (int i = 84; i < 88; i++) rdc(ra(i), (i == 87) ? 32'h7FFF : 32'h8000, 1'b0);
        wres(87, 16'h0055);
        pulse(12'h100);
        for (int i = 84; i < 88; i++) rdc(ra(i), 32'h8000, 1'b0);
        $display("test auxiliary done");
        // reset in mid-run, then a cell conversion alone opens the spin results
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdc(ra(87), 32'h7FFF, 1'b0);
        wres(49, 16'h0456);
        rdc(ra(49), 32'h8000, 1'b0);
        pulse(12'h020);
        wres(49, 16'h0456);
        rdc(ra(49), 32'h0456, 1'b0);
        $display("test mid-run reset done");
        // shunt switches, mute and the discharge timer
        m = 16'($urandom) | 16'h0001;
        apb(1'b1, `CMRB_OFS_DCC, {16'h0, m});
        @(posedge pclk);
        chk({16'h0, shunt}, {16'h0, m});
        pulse(12'h010);
        chk({16'h0, shunt}, 32'h0);
        pulse(12'h008);
        chk({16'h0, shunt}, {16'h0, m});
        apb(1'b1, `CMRB_OFS_DTM, 32'h02);
        pulse(12'h001);
        repeat (20) @(posedge pclk);
        rdc(`CMRB_OFS_DTM, 32'h02, 1'b0);
        apb(1'b1, `CMRB_OFS_DTM, 32'hC1);
        pulse(12'h001);
        repeat (20) @(posedge pclk);
        apb(1'b0, `CMRB_OFS_DTM, 32'h0);
        chk({26'h0, rd[5:0]}, 32'h1);
        chk({16'h0, shunt}, {16'h0, m});
        repeat (60) @(posedge pclk);
        apb(1'b0, `CMRB_OFS_DTM, 32'h0);
        chk({26'h0, rd[5:0]}, 32'h0);
        chk({16'h0, shunt}, 32'h0);
        $display("test shunts and timer done");
        give_verdict();
    end
endmodule
`default_nettype wire
